// [verilog/pfm_consts.svh]
`ifndef PFM_CONSTS_SVH
`define PFM_CONSTS_SVH
`define PFM_NPORTS 11
`define PFM_DAT_BASE 5'h00
`define PFM_DIR_BASE 5'h10
`define PFM_CTRL_ADDR 5'h1e
`define PFM_STAT_ADDR 5'h1f
`define PFM_CTRL_RST 8'h00
`define PFM_LAT_RST 8'h00
`define PFM_DIR_RST 8'h00
`define PFM_C_MEMX 0
`define PFM_C_P42IO 1
`define PFM_C_SUBOUT 2
`define PFM_C_SUBOSC 3
`define PFM_ADDR_B_BITS 20
`endif

// [verilog/pfm_pkg.sv]
package pfm_pkg;
    typedef enum logic [1:0] {PFM_SINGLE, PFM_MEMEXP, PFM_MICRO} pfm_mode_e;
    typedef logic [10:0][7:0] pfm_pins_t;
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic addr_phase;
        logic rd;
        logic wr_lo;
        logic wr_hi;
        logic upper_byte_enable;
        logic ale;
        logic [4:0] chip_select_outputs;
        logic sample_strobe_out;
        logic bus_release_ack;
        logic active;
        logic phi1;
    } pfm_bus_s;
    typedef struct packed {
        pfm_pins_t oe;
        pfm_pins_t out;
    } pfm_alt_s;
endpackage

// [verilog/pfm_sync.sv]
module pfm_sync import pfm_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// [verilog/pfm_mux.sv]
// Decided for this implementation: the register offsets and the plain strobed port.
`include "pfm_consts.svh"
module pfm_mux import pfm_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Mode pins
    input wire logic processor_mode_pin,
    input wire logic bus_width_select,
    input wire logic bus_method_select,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Internal bus side
    input wire pfm_bus_s bus_i,
    output logic [15:0] bus_rdata,
    output logic hold_request,
    output logic ready_in,
    output pfm_mode_e mode_o,
    // Peripheral side
    input wire pfm_alt_s alt_i,
    input wire logic subclock_in,
    input wire logic subclock_osc_output,
    output logic subclock_osc_input,
    output pfm_pins_t periph_pin_o,
    // Pins
    input wire pfm_pins_t pin_in,
    output pfm_pins_t pin_out,
    output pfm_pins_t pin_oe,
    output logic enable_out_n
);
    // ----------------------------------------------------------------
    // Reset release and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_q;
    logic rst_n_s;
    pfm_pins_t pin_s;
    logic cnv_s;
    logic byte_s;
    logic bus_method_select_s;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n_s = rst_q[1];

    pfm_sync #(.W(91)) u_sync (
        .clk(clk),
        .rst_n(rst_n_s),
        .d({pin_in, processor_mode_pin, bus_width_select, bus_method_select}),
        .q({pin_s, cnv_s, byte_s, bus_method_select_s})
    );

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic p9_drv_q;
    pfm_mode_e mode;
    logic ext;
    logic bus_a;
    logic wide;
    logic wr_any;
    logic [23:0] ext_addr;

    assign mode = cnv_s ? PFM_MICRO :
        (ctrl_q[`PFM_C_MEMX] ? PFM_MEMEXP : PFM_SINGLE);
    assign ext = (mode != PFM_SINGLE);
    assign bus_a = bus_method_select_s;
    assign wide = !byte_s;
    assign wr_any = bus_i.wr_lo | bus_i.wr_hi;
    // Bus B reaches only 1 Mbyte, so the top address bits never leave the chip.
    assign ext_addr = bus_a ? bus_i.addr :
        {{(24 - `PFM_ADDR_B_BITS){1'b0}}, bus_i.addr[`PFM_ADDR_B_BITS-1:0]};

    // ----------------------------------------------------------------
    // External bus pin functions, ports 0 to 4
    // ----------------------------------------------------------------
    pfm_pins_t ext_out;
    pfm_pins_t ext_oe;
    pfm_pins_t ext_mask;
    logic p42_io;

    assign ext_out[0] = bus_a ? ext_addr[7:0] :
        {ext_addr[17:16], ~bus_i.sample_strobe_out, ~bus_i.chip_select_outputs};
    assign ext_oe[0] = 8'hff;
    assign ext_out[1] = (wide && !bus_i.addr_phase) ?
        bus_i.wdata[15:8] : ext_addr[15:8];
    assign ext_oe[1] = (!wide || bus_i.addr_phase || wr_any) ? 8'hff : 8'h00;
    assign ext_out[2] = !bus_i.addr_phase ? bus_i.wdata[7:0] :
        (bus_a ? ext_addr[23:16] : ext_addr[7:0]);
    assign ext_oe[2] = (bus_i.addr_phase || wr_any) ? 8'hff : 8'h00;
    assign ext_out[3] = bus_a ?
        {4'h0, bus_i.bus_release_ack, bus_i.ale, ~bus_i.upper_byte_enable, ~wr_any} :
        {4'h0, bus_i.bus_release_ack, bus_i.ale, ~bus_i.wr_hi, ~bus_i.wr_lo};
    assign ext_oe[3] = 8'h0f;
    // Hold and ready are inputs; only the clock bit drives.
    assign ext_out[4] = {5'h00, bus_i.phi1, 2'h0};
    assign ext_oe[4] = 8'h04;
    assign p42_io = (mode == PFM_MEMEXP) && ctrl_q[`PFM_C_P42IO];
    assign ext_mask[0] = 8'hff;
    assign ext_mask[1] = 8'hff;
    assign ext_mask[2] = 8'hff;
    assign ext_mask[3] = 8'h0f;
    assign ext_mask[4] = p42_io ? 8'h03 : 8'h07;
    assign ext_out[10:5] = '0;
    assign ext_oe[10:5] = '0;
    assign ext_mask[10:5] = '0;

    // ----------------------------------------------------------------
    // Subclock pins
    // ----------------------------------------------------------------
    pfm_pins_t sp_out;
    pfm_pins_t sp_oe;
    pfm_pins_t sp_hiz;
    logic sub_out;
    logic sub_osc;

    assign sub_out = ctrl_q[`PFM_C_SUBOUT];
    assign sub_osc = ctrl_q[`PFM_C_SUBOSC];
    always_comb begin
        sp_out = '0;
        sp_oe = '0;
        sp_hiz = '0;
        sp_out[6][7] = subclock_in;
        sp_oe[6][7] = sub_out;
        sp_out[7][6] = subclock_osc_output;
        sp_oe[7][6] = sub_osc;
        // While the subclock oscillator is on, the oscillator input is never driven,
        // whatever its direction bit says, so the port cannot load the resonator.
        sp_hiz[7][7] = sub_osc;
    end
    assign subclock_osc_input = pin_s[7][7];

    // ----------------------------------------------------------------
    // Per-port registers and pin selection
    // ----------------------------------------------------------------
    pfm_pins_t lat_q;
    pfm_pins_t dir_q;
    pfm_pins_t nx_out;
    pfm_pins_t nx_oe;
    pfm_pins_t rd_val;
    pfm_pins_t pin_out_q;
    pfm_pins_t pin_oe_q;

    genvar p;
    genvar b;
    generate
        for (p = 0; p < `PFM_NPORTS; p++) begin : g_port
            logic wr_lat;
            logic wr_dir;
            logic [7:0] base_oe;
            logic [7:0] dir_mask;
            assign wr_lat = reg_wr && (reg_addr == (`PFM_DAT_BASE + 5'(p)));
            assign wr_dir = reg_wr && (reg_addr == (`PFM_DIR_BASE + 5'(p)));
            // Port 3 has four pins, port 9 has no direction register.
            assign dir_mask = (p == 3) ? 8'h0f : ((p == 9) ? 8'h00 : 8'hff);
            always_ff @(posedge clk or negedge rst_n_s) begin
                if (!rst_n_s) begin
                    lat_q[p] <= `PFM_LAT_RST;
                    dir_q[p] <= `PFM_DIR_RST;
                end else begin
                    if (wr_lat) begin
                        lat_q[p] <= reg_wdata;
                    end
                    if (wr_dir) begin
                        dir_q[p] <= reg_wdata & dir_mask;
                    end
                end
            end
            assign base_oe = (p == 9) ? {8{p9_drv_q}} : dir_q[p];
            for (b = 0; b < 8; b++) begin : g_bit
                logic use_ext;
                logic use_alt;
                assign use_ext = ext && ext_mask[p][b];
                assign use_alt = alt_i.oe[p][b];
                assign nx_out[p][b] = use_ext ? ext_out[p][b] :
                    (sp_oe[p][b] ? sp_out[p][b] :
                    (use_alt ? alt_i.out[p][b] : lat_q[p][b]));
                assign nx_oe[p][b] = use_ext ? ext_oe[p][b] :
                    (!sp_hiz[p][b] &&
                    (sp_oe[p][b] | use_alt | base_oe[b]));
            end
            assign rd_val[p] = (base_oe & lat_q[p]) | (~base_oe & pin_s[p]);
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
        end else begin
            pin_out_q <= nx_out;
            pin_oe_q <= nx_oe;
        end
    end
    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;
    assign periph_pin_o = pin_s;

    // ----------------------------------------------------------------
    // Control register and port 9 drive flag
    // ----------------------------------------------------------------
    logic wr_ctrl;
    logic wr_p9;

    assign wr_ctrl = reg_wr && (reg_addr == `PFM_CTRL_ADDR);
    assign wr_p9 = reg_wr && (reg_addr == (`PFM_DAT_BASE + 5'h09));
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctrl_q <= `PFM_CTRL_RST;
            p9_drv_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {4'h0, reg_wdata[3:0]};
            end
            if (wr_p9) begin
                p9_drv_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    logic [3:0] idx;
    logic idx_ok;
    logic hit_dat;
    logic hit_dir;
    logic [7:0] rd_d;
    logic [7:0] rdata_q;

    assign idx = reg_addr[3:0];
    assign idx_ok = (idx < 4'(`PFM_NPORTS));
    assign hit_dat = idx_ok && (reg_addr[4] == `PFM_DAT_BASE >> 4);
    assign hit_dir = idx_ok && (reg_addr[4] == `PFM_DIR_BASE >> 4);
    // Unmapped addresses read as zero.
    assign rd_d = !reg_rd ? 8'h00 :
        hit_dat ? rd_val[idx] :
        hit_dir ? dir_q[idx] :
        (reg_addr == `PFM_CTRL_ADDR) ? ctrl_q :
        (reg_addr == `PFM_STAT_ADDR) ? {3'h0, mode, cnv_s, byte_s, bus_method_select_s} :
        8'h00;
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_d;
        end
    end
    assign reg_rdata = rdata_q;

    // ----------------------------------------------------------------
    // Bus-side outputs
    // ----------------------------------------------------------------
    logic en_d;

    // In bus B the enable pin carries the read strobe instead.
    assign en_d = (ext && !bus_a) ? !bus_i.rd : !bus_i.active;
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            enable_out_n <= 1'b1;
            hold_request <= 1'b0;
            ready_in <= 1'b1;
            bus_rdata <= 16'h0000;
            mode_o <= PFM_SINGLE;
        end else begin
            enable_out_n <= en_d;
            hold_request <= ext && pin_s[4][0];
            ready_in <= !ext || pin_s[4][1];
            bus_rdata <= {wide ? pin_s[1] : 8'h00, pin_s[2]};
            mode_o <= mode;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_s);

    mode_micro_a: assert property (cnv_s |-> mode == PFM_MICRO)
        else $error("mode pin high but not microprocessor");
    reset_float_a: assert property ($rose(rst_n_s) |-> pin_oe_q == '0)
        else $error("pin driven at reset release");
    p0_bus_a_a: assert property (ext && bus_method_select_s |=> pin_out_q[0] == $past(bus_i.addr[7:0]))
        else $error("port 0 lacks address in bus A");
    p0_bus_b_a: assert property (ext && !bus_method_select_s
        |=> pin_out_q[0][4:0] == ~$past(bus_i.chip_select_outputs))
        else $error("port 0 lacks chip selects in bus B");
    p1_wide_a: assert property (ext && !byte_s && !bus_i.addr_phase && wr_any
        |=> pin_out_q[1] == $past(bus_i.wdata[15:8]) && pin_oe_q[1] == 8'hff)
        else $error("port 1 lacks high data");
    p1_narrow_a: assert property (ext && byte_s
        |=> pin_out_q[1] == $past(ext_addr[15:8]) && pin_oe_q[1] == 8'hff)
        else $error("port 1 lacks address on narrow bus");
    p2_addr_a: assert property (ext && bus_method_select_s && bus_i.addr_phase
        |=> pin_out_q[2] == $past(bus_i.addr[23:16]))
        else $error("port 2 lacks high address");
    p3_strobe_a: assert property (ext && !bus_method_select_s
        |=> pin_out_q[3][1:0] == ~{$past(bus_i.wr_hi), $past(bus_i.wr_lo)})
        else $error("port 3 write strobes wrong");
    rd_strobe_a: assert property (ext && !bus_method_select_s |=> enable_out_n == !$past(bus_i.rd))
        else $error("enable pin not read strobe");
    enable_sc_a: assert property (!ext |=> enable_out_n == !$past(bus_i.active))
        else $error("enable pin not access status");
    single_dir_a: assert property (!ext
        |=> pin_oe_q[0] == $past(dir_q[0] | alt_i.oe[0]))
        else $error("single-chip port 0 ignores direction");
    p9_float_a: assert property (!p9_drv_q |-> pin_oe_q[9][7:4] == 4'h0)
        else $error("port 9 driven before latch write");
    // Bus inputs reach the core through the synchronisers only.
    hold_pin_a: assert property (ext |=> hold_request == $past(pin_s[4][0]))
        else $error("hold request not from port 4 bit 0");
    ready_pin_a: assert property (ext |=> ready_in == $past(pin_s[4][1]))
        else $error("ready not from port 4 bit 1");
    single_hold_a: assert property (!ext |=> !hold_request && ready_in)
        else $error("bus inputs active in single-chip");
    p42_clock_a: assert property (ext && !p42_io
        |=> pin_oe_q[4][2] && pin_out_q[4][2] == $past(bus_i.phi1))
        else $error("port 4 bit 2 lacks clock");
    p42_port_a: assert property (p42_io
        |=> pin_oe_q[4][2] == $past(dir_q[4][2] | alt_i.oe[4][2]))
        else $error("port 4 bit 2 not under direction control");
    osc_input_a: assert property (sub_osc |=> !pin_oe_q[7][7])
        else $error("oscillator input pin driven");
    wide_data_a: assert property (ext && !byte_s
        |=> bus_rdata == $past({pin_s[1], pin_s[2]}))
        else $error("wide read data wrong");
    narrow_data_a: assert property (ext && byte_s |=> bus_rdata[15:8] == 8'h00)
        else $error("narrow bus carries high data");

    bus_a_c: cover property (ext && bus_method_select_s && bus_i.addr_phase);
    bus_b_c: cover property (ext && !bus_method_select_s && bus_i.rd);
    p9_wr_c: cover property (wr_p9 ##1 p9_drv_q);
    wide_wr_c: cover property (ext && !byte_s && !bus_i.addr_phase && wr_any);
    p42_io_c: cover property (p42_io && dir_q[4][2]);
endmodule

// [bench/pfm_ext_mem.sv]
module pfm_ext_mem import pfm_pkg::*; (
    // Device pins
    input wire pfm_pins_t pin_out,
    input wire pfm_pins_t pin_oe,
    input wire logic enable_out_n,
    // Board setting
    input wire logic ext_mode,
    input wire logic bus_a,
    input wire logic hold_req,
    input wire logic ready,
    input wire logic [15:0] rd_data,
    // Resolved pin levels
    output pfm_pins_t pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // The memory drives data only in a read; a line that nobody drives shows
    // a fixed idle pattern so a stale level can never pass for fresh data.
    pfm_pins_t drv;
    logic reading;
    assign reading = ext_mode && (bus_a ? pin_out[3][0] : !enable_out_n);
    always_comb begin
        drv = {11{8'h3c}};
        // A resonator ties the oscillator input to its output.
        drv[7][7] = pin_out[7][6];
        if (ext_mode) begin
            drv[4][1:0] = {ready, hold_req};
        end
        if (reading) begin
            drv[2] = rd_data[7:0];
            drv[1] = rd_data[15:8];
        end
    end
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
endmodule

// [bench/test_mcu_port_function_mux.sv]
`include "pfm_consts.svh"
module test_mcu_port_function_mux import pfm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [3:0] port;
        logic [7:0] dir;
        logic [7:0] lat;
        logic [7:0] oe;
    } pfm_row_s;
    logic clk = 1'b0, reset_n = 1'b0, processor_mode_pin = 1'b0;
    logic bus_width_select = 1'b0, bus_method_select = 1'b1;
    logic [4:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, hold_request, ready_in, enable_out_n;
    logic subclock_in = 1'b0, osc_out = 1'b0, subclock_osc_input;
    logic ext = 1'b0, bus_a = 1'b1, hold = 1'b0, ready = 1'b1;
    logic [15:0] bus_rdata, rd_data = '0;
    pfm_bus_s bus = '0;
    pfm_alt_s alt = '0;
    pfm_mode_e mode_o;
    pfm_pins_t pin_in, pin_out, pin_oe;
    int checked = 0, n_errors = 0;
    pfm_row_s rows [5] = '{'{4'd0, 8'hf0, 8'ha5, 8'hf0}, '{4'd3, 8'hff, 8'h0a, 8'h0f},
        '{4'd9, 8'h00, 8'h81, 8'hff}, '{4'd10, 8'h0f, 8'h96, 8'h0f},
        '{4'd8, 8'hff, 8'h5c, 8'hff}};

    always #2.5 clk = ~clk;

    pfm_mux pfm_mux_i (.clk(clk), .reset_n(reset_n), .processor_mode_pin(processor_mode_pin),
        .bus_width_select(bus_width_select), .bus_method_select(bus_method_select),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bus_i(bus), .bus_rdata(bus_rdata),
        .hold_request(hold_request), .ready_in(ready_in), .mode_o(mode_o), .alt_i(alt),
        .subclock_in(subclock_in), .subclock_osc_output(osc_out),
        .subclock_osc_input(subclock_osc_input), .periph_pin_o(), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .enable_out_n(enable_out_n));

    pfm_ext_mem pfm_ext_mem_i (.pin_out(pin_out), .pin_oe(pin_oe),
        .enable_out_n(enable_out_n), .ext_mode(ext), .bus_a(bus_a), .hold_req(hold),
        .ready(ready), .rd_data(rd_data), .pin_in(pin_in));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [87:0] got, input logic [87:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e & m, "register read");
    endtask

    task automatic end_of_test();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        end_of_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        step(3);
        chk(pin_oe, '0, "pins driven in reset");
        chk({enable_out_n, ready_in, hold_request, mode_o}, 5'b11000, "reset state");
        @(posedge clk);
        reset_n <= 1'b1;
        bus_width_select <= 1'b1;
        bus_method_select <= 1'b0;
        // Registers answer only from the third edge after release.
        step(3);
        rd(`PFM_DIR_BASE, `PFM_DIR_RST, 8'hff);
        foreach (rows[i]) begin
            wr(`PFM_DIR_BASE + {1'b0, rows[i].port}, rows[i].dir);
            wr(`PFM_DAT_BASE + {1'b0, rows[i].port}, rows[i].lat);
            step(4);
            chk(pin_oe[rows[i].port], rows[i].oe, "direction");
            chk(pin_out[rows[i].port] & rows[i].oe, rows[i].lat & rows[i].oe, "level");
            rd(`PFM_DAT_BASE + {1'b0, rows[i].port}, (rows[i].lat & rows[i].oe) |
                (8'h3c & ~rows[i].oe), rows[i].port == 4'd3 ? 8'h0f : 8'hff);
        end
        @(posedge clk);
        alt.oe[5][0] <= 1'b1;
        alt.out[5][0] <= 1'b1;
        subclock_in <= 1'b1;
        osc_out <= 1'b1;
        wr(`PFM_CTRL_ADDR, 8'h0c);
        step(4);
        chk({pin_oe[5][0], pin_out[5][0]}, 2'b11, "timer pin");
        chk({pin_out[6][7], pin_out[7][6], subclock_osc_input}, 3'b111, "subclock");
        ext <= 1'b1;
        wr(`PFM_CTRL_ADDR, 8'h03);
        wr(`PFM_DIR_BASE + 5'h04, 8'h04);
        wr(`PFM_DAT_BASE + 5'h04, 8'h04);
        step(5);
        chk(mode_o, PFM_MEMEXP, "memory expansion");
        chk({pin_oe[4][2], pin_out[4][2]}, 2'b11, "clock pin as port");
        @(posedge clk);
        processor_mode_pin <= 1'b1;
        bus_method_select <= 1'b1;
        bus_width_select <= 1'b0;
        hold <= 1'b1;
        ready <= 1'b0;
        bus <= '{addr: 24'h123456, addr_phase: 1'b1, rd: 1'b1, upper_byte_enable: 1'b1,
            ale: 1'b1, active: 1'b1, phi1: 1'b1, default: '0};
        wr(`PFM_CTRL_ADDR, 8'h00);
        step(5);
        chk(mode_o, PFM_MICRO, "microprocessor");
        chk({pin_oe[2:0], pin_out[2:0]}, {24'hffffff, 24'h123456}, "bus A address");
        chk({pin_out[3][3:0], pin_out[4][2]}, 5'b01011, "bus A control");
        chk({hold_request, ready_in, enable_out_n}, 3'b100, "hold ready enable");
        rd(`PFM_STAT_ADDR, 8'h15, 8'hff);
        wr(5'h0c, 8'hff);
        rd(5'h0c, 8'h00, 8'hff);
        @(posedge clk);
        bus.addr_phase <= 1'b0;
        rd_data <= 16'h5aa5;
        step(5);
        chk({pin_oe[1], bus_rdata}, {8'h00, 16'h5aa5}, "wide read");
        @(posedge clk);
        bus <= '{addr: 24'h123456, wdata: 16'hc396, wr_lo: 1'b1, wr_hi: 1'b1,
            upper_byte_enable: 1'b1, active: 1'b1, default: '0};
        step(2);
        chk({pin_oe[2:1], pin_out[2:1]}, 32'hffff96c3, "wide write");
        chk(pin_out[3][3:0], 4'h0, "bus A write control");
        @(posedge clk);
        bus_method_select <= 1'b0;
        bus_width_select <= 1'b1;
        bus_a <= 1'b0;
        rd_data <= 16'h77e1;
        bus <= '{addr: 24'hfabcde, addr_phase: 1'b1, wr_lo: 1'b1, bus_release_ack: 1'b1,
            chip_select_outputs: 5'h01, active: 1'b1, default: '0};
        step(5);
        chk(pin_out[2:0], 24'hdebcbe, "bus B address");
        chk({pin_out[3][3:0], enable_out_n}, 5'b10101, "bus B control");
        @(posedge clk);
        bus <= '{addr: 24'hfabcde, rd: 1'b1, active: 1'b1, default: '0};
        step(5);
        chk({pin_oe[1], enable_out_n, bus_rdata}, {8'hff, 1'b0, 16'h00e1}, "narrow read");
        @(posedge clk);
        reset_n <= 1'b0;
        #1;
        chk(pin_oe, '0, "second reset pins");
        chk(enable_out_n, 1'b1, "second reset enable");
        @(posedge clk);
        reset_n <= 1'b1;
        step(5);
        chk(pin_oe[10:6], '0, "pins after second reset");
        rd(`PFM_DIR_BASE + 5'h08, `PFM_DIR_RST, 8'hff);
        end_of_test();
    end
endmodule
